// ### hdl/shuffle_consts.svh
// Behaviour
// RULE1: In 60 Hz mode slots run divided block, then half, then macro block order, then row term.
// RULE2: In 60 Hz mode the five columns are (4h+s+2t) plus 2, 6, 8, 0, 4, all modulo 10.
// RULE3: In 60 Hz mode the base block number is (5t+25k) mod 135, feeding five blocks in a row.
// RULE4: In 60 Hz mode the sequence number is the integer part of (5t+25k+675s)/135.
// RULE5: Block offsets 0 to 4 carry columns a to e at horizontal positions 2, 1, 3, 0, 4.
// RULE6: In 50 Hz mode the five columns are (4h+i) plus 2, 6, 8, 0, 4, all modulo 11.
// RULE7: In 50 Hz mode slots run divided block, then macro block order, then vertical order 0..10.
// RULE8: In 50 Hz mode the base block number is (5i+55k) mod 135.
// RULE9: In 50 Hz mode the main-unit sequence number is the integer part of (5i+55k)/135.
// RULE10: In 50 Hz mode edge blocks go to channel 0, sequence 11, blocks 5k..5k+4, column 11.
// RULE11: Every video slot carries a 77-byte payload, one compressed macro block.
// RULE12: Every video slot identifier carries section type 100.
// RULE13: In 50 Hz mode sequence 11 of channels 1 to 3 is flagged as empty.
// RULE14: The mode input is set before a frame starts and held for the whole frame.
`ifndef SHUFFLE_CONSTS_SVH
`define SHUFFLE_CONSTS_SVH

`define MAP_SEQ_LEN    11'h087
`define MAP_T_STEP     11'h005
`define MAP_K_STEP60   11'h019
`define MAP_K_STEP50   11'h037
`define MAP_S_STEP     11'h2a3
`define MAP_MOD60      5'h0a
`define MAP_MOD50      5'h0b
`define MAP_H_LAST     2'h3
`define MAP_K_LAST     5'h1a
`define MAP_T_LAST60   4'h4
`define MAP_I_LAST50   4'ha
`define MAP_P_LAST     3'h4
`define MAP_EDGE_SEQ   4'hb
`define MAP_EDGE_COL   4'hb
`define MAP_BLK_LAST   8'h86
`define MAP_PAYLOAD    7'h4d
`define MAP_SECTION    3'h4
`define MAP_OFF0       5'h02
`define MAP_OFF1       5'h06
`define MAP_OFF2       5'h08
`define MAP_OFF3       5'h00
`define MAP_OFF4       5'h04
`define MAP_POS0       3'h2
`define MAP_POS1       3'h1
`define MAP_POS2       3'h3
`define MAP_POS3       3'h0
`define MAP_POS4       3'h4

`endif

// ### hdl/shuffle_pkg.sv
package shuffle_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_MAIN, PH_EDGE, PH_EMPTY} phase_t;

    typedef struct packed {
        phase_t     phase;
        logic       m50;
        logic       busy;
        logic [1:0] h;
        logic       s;
        logic [4:0] k;
        logic [3:0] t;
        logic [2:0] p;
        logic [7:0] blk;
        logic       valid;
        logic [3:0] seq;
        logic [7:0] dbn;
        logic [3:0] col;
        logic [2:0] hpos;
        logic [4:0] ord;
        logic [1:0] ch;
        logic       empty;
        logic       done;
        logic [2:0] sect;
        logic [6:0] len;
    } state_t;

endpackage

// ### hdl/shuffle_div.sv
`timescale 1ns/1ps
`include "shuffle_consts.svh"

module shuffle_div (
    input  wire logic [10:0] val,
    output logic      [3:0]  quo,
    output logic      [7:0]  rem
);

    logic [10:0] ge;
    logic [10:0] prod;

    genvar j;
    generate
        for (j = 1; j <= 11; j++) begin : g_thr
            assign ge[j-1] = (val >= 11'(j * `MAP_SEQ_LEN));
        end
    endgenerate

    always_comb begin
        quo = 4'h0;
        for (int m = 0; m < 11; m++) begin
            quo = quo + {3'h0, ge[m]};
        end
        prod = 11'(quo) * `MAP_SEQ_LEN;
        rem  = 8'(val - prod);
    end

endmodule

// ### hdl/shuffle_mapper.sv
`timescale 1ns/1ps
`include "shuffle_consts.svh"

module shuffle_mapper
    import shuffle_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       ARST_N,
    input  wire logic       START,
    input  wire logic       MODE_50HZ,
    input  wire logic       SLOT_READY,
    output logic            SLOT_VALID,
    output logic [1:0]      SLOT_CHANNEL,
    output logic [3:0]      DIF_SEQUENCE_INDEX,
    output logic [7:0]      DIF_BLOCK_INDEX,
    output logic            SLOT_EMPTY,
    output logic [2:0]      SLOT_SECTION,
    output logic [6:0]      SLOT_PAYLOAD_LEN,
    output logic [1:0]      MB_DIVIDED,
    output logic [3:0]      MB_COLUMN,
    output logic [2:0]      MB_POSITION,
    output logic [4:0]      MB_ORDER,
    output logic            BUSY,
    output logic            FRAME_DONE
);

    localparam state_t ST_RESET = '{phase: PH_IDLE, sect: `MAP_SECTION, len: `MAP_PAYLOAD,
                                    default: '0};

    state_t      st_reg;
    state_t      st_next;
    logic [10:0] acc;
    logic [3:0]  quo;
    logic [7:0]  rem;
    logic [4:0]  off;
    logic [2:0]  hpos;
    logic [4:0]  modv;
    logic [4:0]  col_sum;
    logic [4:0]  col;
    logic [7:0]  edge_blk;
    logic        take;
    logic        p_wrap;
    logic        t_wrap;
    logic        k_wrap;
    logic        s_wrap;
    logic        h_wrap;

    // RULE4 RULE9 sequence and base
    shuffle_div u_div (
        .val (acc),
        .quo (quo),
        .rem (rem)
    );

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        // RULE3 RULE4 RULE8 running sum
        acc = 11'(st_reg.t) * `MAP_T_STEP
            + 11'(st_reg.k) * (st_reg.m50 ? `MAP_K_STEP50 : `MAP_K_STEP60)
            + ((!st_reg.m50 && st_reg.s) ? `MAP_S_STEP : 11'h000);
        // RULE5 offset and position per slot
        case (st_reg.p)
            3'h0: begin
                off  = `MAP_OFF0;
                hpos = `MAP_POS0;
            end
            3'h1: begin
                off  = `MAP_OFF1;
                hpos = `MAP_POS1;
            end
            3'h2: begin
                off  = `MAP_OFF2;
                hpos = `MAP_POS2;
            end
            3'h3: begin
                off  = `MAP_OFF3;
                hpos = `MAP_POS3;
            end
            default: begin
                off  = `MAP_OFF4;
                hpos = `MAP_POS4;
            end
        endcase
        // RULE2 RULE6 column modulo 10 or 11
        modv    = st_reg.m50 ? `MAP_MOD50 : `MAP_MOD60;
        col_sum = {1'b0, st_reg.h, 2'b00} + off
                + (st_reg.m50 ? {1'b0, st_reg.t} : ({st_reg.t, 1'b0} + {4'h0, st_reg.s}));
        col = col_sum;
        if (col >= modv) col = col - modv;
        if (col >= modv) col = col - modv;
        // RULE10 edge block number
        edge_blk = 8'(11'(st_reg.k) * `MAP_T_STEP) + {5'h00, st_reg.p};
        // RULE1 RULE7 loop nesting
        p_wrap = (st_reg.p == `MAP_P_LAST);
        t_wrap = p_wrap && (st_reg.t == (st_reg.m50 ? `MAP_I_LAST50 : `MAP_T_LAST60));
        k_wrap = t_wrap && (st_reg.k == `MAP_K_LAST);
        s_wrap = k_wrap && (st_reg.m50 || st_reg.s);
        h_wrap = s_wrap && (st_reg.h == `MAP_H_LAST);
        take   = !st_reg.valid || SLOT_READY;
        if (st_reg.valid && SLOT_READY) st_next.valid = 1'b0;
        case (st_reg.phase)
            PH_IDLE: begin
                if (START) begin
                    st_next.phase = PH_MAIN;
                    // RULE14 mode held per frame
                    st_next.m50   = MODE_50HZ;
                    st_next.busy  = 1'b1;
                    st_next.h     = 2'h0;
                    st_next.s     = 1'b0;
                    st_next.k     = 5'h00;
                    st_next.t     = 4'h0;
                    st_next.p     = 3'h0;
                end
            end
            PH_MAIN: begin
                if (take) begin
                    st_next.valid = 1'b1;
                    st_next.ch    = st_reg.h;
                    st_next.seq   = quo;
                    // RULE3 RULE8 five blocks from base
                    st_next.dbn   = rem + {5'h00, st_reg.p};
                    st_next.col   = col[3:0];
                    st_next.hpos  = hpos;
                    st_next.ord   = st_reg.k;
                    st_next.empty = 1'b0;
                    st_next.p     = p_wrap ? 3'h0 : st_reg.p + 3'h1;
                    if (p_wrap) st_next.t = t_wrap ? 4'h0 : st_reg.t + 4'h1;
                    if (t_wrap) st_next.k = k_wrap ? 5'h00 : st_reg.k + 5'h01;
                    if (k_wrap && !st_reg.m50) st_next.s = ~st_reg.s;
                    if (s_wrap) st_next.h = st_reg.h + 2'h1;
                    if (h_wrap) begin
                        if (st_reg.m50) begin
                            st_next.phase = PH_EDGE;
                        end else begin
                            st_next.phase = PH_IDLE;
                            st_next.busy  = 1'b0;
                            st_next.done  = 1'b1;
                        end
                    end
                end
            end
            PH_EDGE: begin
                if (take) begin
                    // RULE10 edge unit slots
                    st_next.valid = 1'b1;
                    st_next.ch    = 2'h0;
                    st_next.seq   = `MAP_EDGE_SEQ;
                    st_next.dbn   = edge_blk;
                    st_next.col   = `MAP_EDGE_COL;
                    st_next.hpos  = st_reg.p;
                    st_next.ord   = st_reg.k;
                    st_next.empty = 1'b0;
                    st_next.p     = p_wrap ? 3'h0 : st_reg.p + 3'h1;
                    if (p_wrap) st_next.k = st_reg.k + 5'h01;
                    if (p_wrap && st_reg.k == `MAP_K_LAST) begin
                        st_next.phase = PH_EMPTY;
                        st_next.k     = 5'h00;
                        st_next.h     = 2'h1;
                        st_next.blk   = 8'h00;
                    end
                end
            end
            PH_EMPTY: begin
                if (take) begin
                    // RULE13 unused sequence marked empty
                    st_next.valid = 1'b1;
                    st_next.ch    = st_reg.h;
                    st_next.seq   = `MAP_EDGE_SEQ;
                    st_next.dbn   = st_reg.blk;
                    st_next.col   = 4'h0;
                    st_next.hpos  = 3'h0;
                    st_next.ord   = 5'h00;
                    st_next.empty = 1'b1;
                    st_next.blk   = st_reg.blk + 8'h01;
                    if (st_reg.blk == `MAP_BLK_LAST) begin
                        st_next.blk = 8'h00;
                        st_next.h   = st_reg.h + 2'h1;
                        if (st_reg.h == `MAP_H_LAST) begin
                            st_next.phase = PH_IDLE;
                            st_next.busy  = 1'b0;
                            st_next.done  = 1'b1;
                        end
                    end
                end
            end
            default: st_next = ST_RESET;
        endcase
        // RULE11 RULE12 fixed identifier fields
        st_next.sect = `MAP_SECTION;
        st_next.len  = `MAP_PAYLOAD;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign SLOT_VALID         = st_reg.valid;
    assign SLOT_CHANNEL       = st_reg.ch;
    assign DIF_SEQUENCE_INDEX = st_reg.seq;
    assign DIF_BLOCK_INDEX    = st_reg.dbn;
    assign SLOT_EMPTY         = st_reg.empty;
    assign SLOT_SECTION       = st_reg.sect;
    assign SLOT_PAYLOAD_LEN   = st_reg.len;
    assign MB_DIVIDED         = st_reg.ch;
    assign MB_COLUMN          = st_reg.col;
    assign MB_POSITION        = st_reg.hpos;
    assign MB_ORDER           = st_reg.ord;
    assign BUSY               = st_reg.busy;
    assign FRAME_DONE         = st_reg.done;

    property p_rule1;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && SLOT_READY && !st_reg.m50 && st_reg.phase == PH_MAIN && st_reg.p != 3'h0)
            |=> SLOT_VALID && $stable(SLOT_CHANNEL) && $stable(MB_ORDER);
    endproperty
    a_rule1: assert property (p_rule1) else $error("group split across channel"); // RULE1

    property p_rule2;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && !SLOT_EMPTY && !st_reg.m50) |-> MB_COLUMN < 4'ha;
    endproperty
    a_rule2: assert property (p_rule2) else $error("60 Hz column out of range"); // RULE2

    property p_rule3;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        SLOT_VALID |-> DIF_BLOCK_INDEX <= `MAP_BLK_LAST;
    endproperty
    a_rule3: assert property (p_rule3) else $error("block number above 134"); // RULE3

    property p_rule4;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && !SLOT_EMPTY && !st_reg.m50) |-> DIF_SEQUENCE_INDEX <= 4'h9;
    endproperty
    a_rule4: assert property (p_rule4) else $error("60 Hz sequence above 9"); // RULE4

    property p_rule5;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && DIF_SEQUENCE_INDEX != `MAP_EDGE_SEQ && DIF_BLOCK_INDEX % 8'h05 == 8'h00)
            |-> MB_POSITION == `MAP_POS0;
    endproperty
    a_rule5: assert property (p_rule5) else $error("base slot position wrong"); // RULE5

    property p_rule9;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && st_reg.m50 && !SLOT_EMPTY && MB_COLUMN != `MAP_EDGE_COL)
            |-> DIF_SEQUENCE_INDEX <= 4'ha;
    endproperty
    a_rule9: assert property (p_rule9) else $error("50 Hz main sequence above 10"); // RULE9

    property p_rule10;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && !SLOT_EMPTY && DIF_SEQUENCE_INDEX == `MAP_EDGE_SEQ)
            |-> SLOT_CHANNEL == 2'h0 && MB_COLUMN == `MAP_EDGE_COL
                && DIF_BLOCK_INDEX == 8'(11'(MB_ORDER) * `MAP_T_STEP) + {5'h00, MB_POSITION};
    endproperty
    a_rule10: assert property (p_rule10) else $error("edge slot mapping wrong"); // RULE10

    property p_rule11;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && !SLOT_READY) |=> SLOT_VALID && $stable(DIF_BLOCK_INDEX)
            && SLOT_PAYLOAD_LEN == `MAP_PAYLOAD;
    endproperty
    a_rule11: assert property (p_rule11) else $error("stalled slot changed"); // RULE11

    property p_rule12;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        SLOT_VALID |-> SLOT_SECTION == `MAP_SECTION;
    endproperty
    a_rule12: assert property (p_rule12) else $error("section type not video"); // RULE12

    property p_rule13;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (SLOT_VALID && SLOT_EMPTY)
            |-> SLOT_CHANNEL != 2'h0 && DIF_SEQUENCE_INDEX == `MAP_EDGE_SEQ
                && MB_COLUMN == 4'h0 && MB_ORDER == 5'h00;
    endproperty
    a_rule13: assert property (p_rule13) else $error("empty slot misplaced"); // RULE13

    property p_rule7;
        @(posedge CORE_CLK) disable iff (!ARST_N)
        (START && st_reg.phase == PH_IDLE) |=> BUSY ##1 SLOT_VALID;
    endproperty
    a_rule7: assert property (p_rule7) else $error("frame start not followed by slot"); // RULE7

endmodule

// ### verification/slot_sink.sv
`timescale 1ns/1ps

// Formatter stand-in: accepts slots, stalls when told to
module slot_sink (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic stall,
    output logic      slot_ready
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_ready <= 1'b0;
        end else begin
            slot_ready <= !stall;
        end
    end
endmodule

// ### verification/tb_shuffle_mapper.sv
`timescale 1ns/1ps

module tb_shuffle_mapper;
    logic        core_clk;
    logic        arst_n;
    logic        start;
    logic        mode_50hz;
    logic        stall = 1'b0;
    logic        slot_ready;
    logic        slot_valid;
    logic [1:0]  slot_channel;
    logic [1:0]  mb_divided;
    logic [3:0]  seq;
    logic [7:0]  blk;
    logic        slot_empty;
    logic [2:0]  section;
    logic [6:0]  len;
    logic [3:0]  column;
    logic [2:0]  position;
    logic [4:0]  order;
    logic        busy;
    logic        frame_done;
    logic [31:0] rng = 32'hc55e;
    logic [38:0] exp_q[$];
    int          failures;
    int          comparisons;
    wire  [38:0] got = {slot_channel, mb_divided, seq, blk, slot_empty, column,
                        position, order, section, len};

    shuffle_mapper i_shuffle_mapper (
        .CORE_CLK           (core_clk),
        .ARST_N             (arst_n),
        .START              (start),
        .MODE_50HZ          (mode_50hz),
        .SLOT_READY         (slot_ready),
        .SLOT_VALID         (slot_valid),
        .SLOT_CHANNEL       (slot_channel),
        .DIF_SEQUENCE_INDEX (seq),
        .DIF_BLOCK_INDEX    (blk),
        .SLOT_EMPTY         (slot_empty),
        .SLOT_SECTION       (section),
        .SLOT_PAYLOAD_LEN   (len),
        .MB_DIVIDED         (mb_divided),
        .MB_COLUMN          (column),
        .MB_POSITION        (position),
        .MB_ORDER           (order),
        .BUSY               (busy),
        .FRAME_DONE         (frame_done)
    );

    slot_sink i_slot_sink (
        .clk        (core_clk),
        .arst_n     (arst_n),
        .stall      (stall),
        .slot_ready (slot_ready)
    );

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [38:0] slot(input int ch, input int q, input int b,
                                         input int e, input int col, input int pos,
                                         input int k);
        return {ch[1:0], ch[1:0], q[3:0], b[7:0], e[0], col[3:0], pos[2:0], k[4:0],
                3'h4, 7'h4d};
    endfunction

    task automatic check(input string what, input logic [38:0] e, input logic [38:0] g);
        comparisons++;
        if (e !== g) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic plan_frame(input logic m50);
        int offs[5];
        int posv[5];
        int b;
        int q;
        offs = '{2, 6, 8, 0, 4};
        posv = '{2, 1, 3, 0, 4};
        for (int h = 0; h < 4; h++) begin
            for (int s = 0; s < (m50 ? 1 : 2); s++) begin
                for (int k = 0; k < 27; k++) begin
                    for (int t = 0; t < (m50 ? 11 : 5); t++) begin
                        b = m50 ? (5 * t + 55 * k) % 135 : (5 * t + 25 * k) % 135;
                        q = m50 ? (5 * t + 55 * k) / 135 : (5 * t + 25 * k + 675 * s) / 135;
                        for (int p = 0; p < 5; p++) begin
                            exp_q.push_back(slot(h, q, b + p, 0, m50 ?
                                (4 * h + t + offs[p]) % 11 : (4 * h + s + 2 * t + offs[p]) % 10,
                                posv[p], k));
                        end
                    end
                end
            end
        end
        if (m50) begin
            for (int k = 0; k < 27; k++) begin
                for (int p = 0; p < 5; p++) begin
                    exp_q.push_back(slot(0, 11, 5 * k + p, 0, 11, p, k));
                end
            end
            for (int c = 1; c < 4; c++) begin
                for (int b2 = 0; b2 < 135; b2++) begin
                    exp_q.push_back(slot(c, 11, b2, 1, 0, 0, 0));
                end
            end
        end
    endtask

    task automatic run_frame(input logic m50, input int refuse_at);
        start <= 1'b1;
        mode_50hz <= m50;
        plan_frame(m50);
        @(posedge core_clk);
        start <= 1'b0;
        @(negedge core_clk);
        check("busy", 39'h1, {38'h0, busy});
        for (int n = 0; n <= 20000; n++) begin
            @(posedge core_clk);
            start <= (n == refuse_at);
            mode_50hz <= m50;
            if (frame_done === 1'b1) begin
                break;
            end
            if (n == 20000) begin
                failures++;
                results();
            end
        end
        @(negedge core_clk);
        check("left", slot_valid ? 39'h1 : 39'h0, 39'(exp_q.size()));
        check("idle", 39'h0, {38'h0, busy});
        @(posedge core_clk);
    endtask

    task automatic check_reset;
        @(negedge core_clk);
        check("reset", {25'h0, 7'h04, 7'h4d},
              {25'h0, slot_valid, busy, frame_done, slot_empty, section, len});
    endtask

    always @(posedge core_clk) begin
        rng <= xorshift(rng);
        stall <= (rng[1:0] == 2'h0);
    end

    always @(posedge core_clk) begin
        if (arst_n && slot_valid === 1'b1 && slot_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra", 39'h0, got);
            end else begin
                check("slot", exp_q.pop_front(), got);
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        arst_n = 1'b0;
        start = 1'b0;
        mode_50hz = 1'b0;
        failures = 0;
        comparisons = 0;
        repeat (4) @(posedge core_clk);
        check_reset();
        @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        run_frame(1'b0, 100);
        run_frame(1'b1, 3000);
        start <= 1'b1;
        mode_50hz <= 1'b0;
        plan_frame(1'b0);
        @(posedge core_clk);
        start <= 1'b0;
        repeat (40) @(posedge core_clk);
        arst_n <= 1'b0;
        check_reset();
        exp_q.delete();
        @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        run_frame(1'b0, -1);
        for (int n = 0; n < 100 && exp_q.size() != 0; n++) begin
            @(posedge core_clk);
        end
        check("drain", 39'h0, 39'(exp_q.size()));
        results();
    end
endmodule
